// >>> rtl/umc_pins_top.sv
// Pin-level logic of the USB modem bridge controller
`timescale 1ns/1ns
module umc_pins_top
(
	// Clock and system reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Reset pin and straps
	input  wire logic        reset_pin,
	input  wire logic        code_source_strap,
	input  wire logic        full_speed_strap,
	input  wire logic        loop_select_strap,
	// Interrupt, wake and sense pins
	input  wire logic        host_irq_input,
	input  wire logic        ring_wake_input,
	input  wire logic        overcurrent_sense,
	// External memory bus pins
	output logic             addr_latch,
	input  wire logic [7:0]  muxed_addr_data_port_i,
	output logic [7:0]       muxed_addr_data_port_o,
	output logic [7:0]       muxed_addr_data_port_oe,
	output logic [7:0]       high_address_port,
	output logic             program_fetch_strobe_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	// Indicator and modem control pins
	output logic             led_ready_n,
	output logic             led_carrier_detect_n,
	output logic             led_data_n,
	output logic             isolated_power_switch_n,
	output logic             modem_side_reset_out_n,
	output logic             frame_start_n,
	// Core memory requests
	input  wire logic        mem_req,
	input  wire logic [2:0]  mem_kind,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	output logic             mem_ready,
	output logic             mem_done,
	output logic [7:0]       mem_rdata,
	output logic             mem_on_chip,
	// Core controls
	input  wire logic        core_ready_led,
	input  wire logic        core_carrier_led,
	input  wire logic        core_data_led,
	input  wire logic        core_power_on,
	input  wire logic        core_modem_reset,
	input  wire logic        frame_locked,
	input  wire logic        sof_seen,
	input  wire logic        enter_idle,
	input  wire logic        enter_powerdown,
	// Core status
	output logic [2:0]       mode,
	output logic             full_reset,
	output logic             code_off_chip,
	output logic             full_speed_mode,
	output logic             overcurrent,
	output logic             host_irq_line,
	output logic             ring_notify
);

	umc_mem_if mif ();

	logic              blk_rst;
	logic              in_rst_q;
	logic [6:0]        hold_cnt_q;
	logic [1:0]        rpin_q;
	logic [1:0]        code_q;
	logic [1:0]        fs_q;
	logic [1:0]        pll_q;
	logic [1:0]        irq_q;
	logic [2:0]        ring_q;
	logic [1:0]        ovr_q;
	logic              code_strap_q;
	logic              full_speed_q;
	logic              overcurrent_q;
	logic              host_irq_q;
	logic              ring_notify_q;
	umc_pkg::umc_mode_t mode_q;
	logic [3:0]        sof_cnt_q;
	logic              frame_start_n_q;
	logic              on_chip_q;
	logic              take;
	logic              inside_rom;
	logic [2:0]        since_q;

	function automatic logic rom_hit(input logic [2:0] kind, input logic [15:0] addr,
		input logic strap);
		rom_hit = (kind == umc_pkg::ACC_CODE) && strap && (addr < umc_pkg::ROM_LIMIT);
	endfunction

	// =====================================================
	// Pin synchronisers
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			rpin_q <= 2'b00;
			code_q <= {code_q[0], code_source_strap}; // R17
			fs_q   <= 2'b00;
			pll_q  <= 2'b00;
			irq_q  <= 2'b00;
			ring_q <= 3'b111;
			ovr_q  <= 2'b11;
		end
		else
		begin
			rpin_q <= {rpin_q[0], reset_pin};
			code_q <= {code_q[0], code_source_strap};
			fs_q   <= {fs_q[0], full_speed_strap};
			pll_q  <= {pll_q[0], loop_select_strap};
			irq_q  <= {irq_q[0], host_irq_input};
			ring_q <= {ring_q[1:0], ring_wake_input};
			ovr_q  <= {ovr_q[0], overcurrent_sense};
		end
	end

	// =====================================================
	// Reset pin hold counter
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !rpin_q[1])
			hold_cnt_q <= 7'h00;
		else if (hold_cnt_q != 7'(umc_pkg::RST_HOLD_CYC))
			hold_cnt_q <= hold_cnt_q + 7'h01; // R1
	end

	assign full_reset = (hold_cnt_q == 7'(umc_pkg::RST_HOLD_CYC)); // R1
	assign blk_rst    = !rst_n || full_reset;

	// =====================================================
	// Strap capture at reset release
	always_ff @(posedge sys_clk)
	begin
		in_rst_q <= blk_rst;
		if (!rst_n)
			code_strap_q <= umc_pkg::STRAP_RST;
		else if (in_rst_q && !blk_rst)
			code_strap_q <= code_q[1]; // R17
	end

	assign code_off_chip = !code_strap_q;

	// =====================================================
	// Power mode
	always_ff @(posedge sys_clk)
	begin
		if (blk_rst || rpin_q[1])
			mode_q <= umc_pkg::MODE_NORMAL; // R2
		else
		begin
			case (mode_q)
				umc_pkg::MODE_NORMAL:
				begin
					if (enter_powerdown)
						mode_q <= umc_pkg::MODE_PDOWN;
					else if (enter_idle)
						mode_q <= umc_pkg::MODE_IDLE;
				end
				umc_pkg::MODE_IDLE:  mode_q <= umc_pkg::MODE_IDLE;
				umc_pkg::MODE_PDOWN: mode_q <= umc_pkg::MODE_PDOWN;
				default:             mode_q <= umc_pkg::MODE_NORMAL;
			endcase
		end
	end

	assign mode = mode_q;

	// =====================================================
	// Frame start pulse
	always_ff @(posedge sys_clk)
	begin
		if (blk_rst)
		begin
			sof_cnt_q       <= 4'h0;
			frame_start_n_q <= umc_pkg::PIN_IDLE;
		end
		else if (frame_start_n_q && frame_locked && sof_seen)
		begin
			sof_cnt_q       <= 4'(umc_pkg::SOF_PULSE_CYC - 1); // R3
			frame_start_n_q <= 1'b0;
		end
		else if (sof_cnt_q != 4'h0)
			sof_cnt_q <= sof_cnt_q - 4'h1;
		else
			frame_start_n_q <= umc_pkg::PIN_IDLE;
	end

	assign frame_start_n = frame_start_n_q;

	// =====================================================
	// Interrupt, wake, sense and speed status
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			host_irq_q    <= 1'b0;
			ring_notify_q <= 1'b0;
			overcurrent_q <= 1'b0;
			full_speed_q  <= 1'b0;
		end
		else
		begin
			host_irq_q    <= irq_q[1]; // R4
			ring_notify_q <= !ring_q[1] && ring_q[2]; // R5
			overcurrent_q <= !ovr_q[1]; // R15
			full_speed_q  <= fs_q[1] && pll_q[1]; // R14
		end
	end

	assign host_irq_line   = host_irq_q;
	assign ring_notify     = ring_notify_q;
	assign overcurrent     = overcurrent_q;
	assign full_speed_mode = full_speed_q;

	// =====================================================
	// Indicator and modem control outputs
	always_ff @(posedge sys_clk)
	begin
		if (blk_rst)
		begin
			led_ready_n             <= umc_pkg::PIN_IDLE;
			led_carrier_detect_n    <= umc_pkg::PIN_IDLE;
			led_data_n              <= umc_pkg::PIN_IDLE;
			isolated_power_switch_n <= umc_pkg::PIN_IDLE;
			modem_side_reset_out_n  <= umc_pkg::PIN_IDLE;
		end
		else
		begin
			led_ready_n             <= !core_ready_led; // R11
			led_carrier_detect_n    <= !core_carrier_led; // R11
			led_data_n              <= !core_data_led; // R11
			isolated_power_switch_n <= !core_power_on; // R12
			modem_side_reset_out_n  <= !core_modem_reset; // R13
		end
	end

	// =====================================================
	// Memory request routing
	assign inside_rom = rom_hit(mem_kind, mem_addr, code_strap_q); // R17
	assign mem_ready  = !blk_rst && mode_q == umc_pkg::MODE_NORMAL && !mif.busy && !on_chip_q;
	assign take       = mem_req && mem_ready;
	assign mif.req    = take && !inside_rom;
	assign mif.kind   = umc_pkg::umc_acc_t'(mem_kind);
	assign mif.addr   = mem_addr;
	assign mif.wdata  = mem_wdata;

	always_ff @(posedge sys_clk)
	begin
		if (blk_rst)
			on_chip_q <= 1'b0;
		else
			on_chip_q <= take && inside_rom;
	end

	assign mem_done    = mif.done || on_chip_q;
	assign mem_rdata   = mif.rdata;
	assign mem_on_chip = on_chip_q;

	umc_ext_bus u_bus
	(
		.sys_clk                 (sys_clk),
		.core_rst                (blk_rst),
		.mif                     (mif),
		.addr_latch              (addr_latch),
		.muxed_addr_data_port_i  (muxed_addr_data_port_i),
		.muxed_addr_data_port_o  (muxed_addr_data_port_o),
		.muxed_addr_data_port_oe (muxed_addr_data_port_oe),
		.high_address_port       (high_address_port),
		.program_fetch_strobe_n  (program_fetch_strobe_n),
		.read_strobe_n           (read_strobe_n),
		.write_strobe_n          (write_strobe_n)
	);

	// =====================================================
	// Checks
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			since_q <= 3'h0;
		else if (since_q != 3'(umc_pkg::SETTLE_CYC))
			since_q <= since_q + 3'h1;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_full_reset_hold: assert property ($rose(full_reset) |-> $past(rpin_q[1], 64)
		&& $past(rpin_q[1])) // R1
		else $error("full reset without held reset pin");
	a_reset_release: assert property (!rpin_q[1] |=> !full_reset) // R1
		else $error("full reset outlived reset pin");
	a_mode_wakeup: assert property (rpin_q[1] |=> mode_q == umc_pkg::MODE_NORMAL) // R2
		else $error("reset pin did not restore normal mode");
	a_sof_pulse_len: assert property ($fell(frame_start_n) |-> (!frame_start_n)[*8]
		##1 frame_start_n) // R3
		else $error("frame start pulse length wrong");
	a_sof_trigger: assert property (frame_start_n && frame_locked && sof_seen && !blk_rst
		|=> !frame_start_n) // R3
		else $error("frame start missed");
	a_irq_follow: assert property (since_q == 3'h7 |-> host_irq_line == $past(host_irq_input, 3)) // R4
		else $error("host interrupt line does not follow pin");
	a_ring_edge: assert property (since_q == 3'h7 && ring_notify |-> !$past(ring_wake_input, 3)
		&& $past(ring_wake_input, 4)) // R5
		else $error("ring notify without falling ring input");
	a_overcurrent_flag: assert property (since_q == 3'h7 |-> overcurrent
		== !$past(overcurrent_sense, 3)) // R15
		else $error("overcurrent flag mismatch");
	a_speed_select: assert property (since_q == 3'h7 |-> full_speed_mode
		== ($past(full_speed_strap, 3) && $past(loop_select_strap, 3))) // R14
		else $error("full speed select mismatch");
	a_led_drive: assert property (!$past(blk_rst) |-> led_ready_n == !$past(core_ready_led)
		&& led_data_n == !$past(core_data_led)) // R11
		else $error("indicator output mismatch");
	a_strap_capture: assert property ($fell(blk_rst) |=> code_off_chip == !$past(code_q[1])) // R17
		else $error("code source strap not latched at release");
	a_strap_stable: assert property (!blk_rst && !$fell(blk_rst) |=> $stable(code_off_chip)) // R17
		else $error("code source strap changed after reset");
	a_modem_ctl: assert property (!$past(blk_rst) |-> modem_side_reset_out_n
		== !$past(core_modem_reset) && isolated_power_switch_n == !$past(core_power_on)) // R12 R13
		else $error("modem control output mismatch");

endmodule

// >>> rtl/umc_pkg.sv
// Constants and types for the modem bridge pin block
// How it works
// [R1] Reset pin high 64 cycles forces full reset
// [R2] Reset pin ends idle or powerdown mode
// [R3] Frame start pulse low for 8 states
// [R4] Modem controller drives host interrupt high on events
// [R5] Ring wake edge notifies host to resume
// [R6] Low address byte multiplexed with data, open drain
// [R7] High address byte on separate output port
// [R8] Fetch strobe only for external program reads
// [R9] Read strobe only for external data reads
// [R10] Write strobe for every external write
// [R11] Three active-low indicator outputs light LEDs
// [R12] Active-low switch for isolated side power
// [R13] Active-low reset for modem side parts
// [R14] Both speed straps high select full speed
// [R15] Low overcurrent sense flags downstream overcurrent
// [R16] Address latch pulse opens each bus cycle
// [R17] Code source strap latched at reset release
// [R18] Write data held throughout write strobe
package umc_pkg;

	// =====================================================
	// Timing counts
	localparam int RST_HOLD_CYC  = 64;
	localparam int SOF_STATES    = 8;
	localparam int CLK_PER_STATE = 1;
	localparam int SOF_PULSE_CYC = SOF_STATES * CLK_PER_STATE;
	localparam int STRB_CYC      = 4;
	localparam int SETTLE_CYC    = 7;

	// =====================================================
	// Reset values and memory map
	localparam logic       PIN_IDLE    = 1'b1;
	localparam logic [7:0] HI_ADDR_RST = 8'hFF;
	localparam logic [7:0] DATA_RST    = 8'h00;
	localparam logic       STRAP_RST   = 1'b0;
	localparam logic [15:0] ROM_LIMIT  = 16'h2000;

	// =====================================================
	// Enumerations
	typedef enum logic [2:0]
	{
		ACC_CODE  = 3'b001,
		ACC_READ  = 3'b010,
		ACC_WRITE = 3'b100
	} umc_acc_t;

	typedef enum logic [2:0]
	{
		MODE_NORMAL = 3'b001,
		MODE_IDLE   = 3'b010,
		MODE_PDOWN  = 3'b100
	} umc_mode_t;

	typedef enum logic [4:0]
	{
		BUS_IDLE = 5'b00001,
		BUS_ADDR = 5'b00010,
		BUS_HOLD = 5'b00100,
		BUS_STRB = 5'b01000,
		BUS_END  = 5'b10000
	} umc_bus_t;

endpackage

// >>> rtl/umc_mem_if.sv
// Request and answer carrier between core logic and bus engine
`timescale 1ns/1ns
interface umc_mem_if;
	logic             req;
	umc_pkg::umc_acc_t kind;
	logic [15:0]      addr;
	logic [7:0]       wdata;
	logic             busy;
	logic             done;
	logic [7:0]       rdata;

	modport host
	(
		output req, kind, addr, wdata,
		input  busy, done, rdata
	);
	modport engine
	(
		input  req, kind, addr, wdata,
		output busy, done, rdata
	);
endinterface

// >>> rtl/umc_ext_bus.sv
// External memory bus cycle engine
`timescale 1ns/1ns
module umc_ext_bus
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       core_rst,
	// Request side
	umc_mem_if.engine       mif,
	// Bus pins
	output logic            addr_latch,
	input  wire logic [7:0] muxed_addr_data_port_i,
	output logic [7:0]      muxed_addr_data_port_o,
	output logic [7:0]      muxed_addr_data_port_oe,
	output logic [7:0]      high_address_port,
	output logic            program_fetch_strobe_n,
	output logic            read_strobe_n,
	output logic            write_strobe_n
);

	umc_pkg::umc_bus_t st_q;
	umc_pkg::umc_acc_t kind_q;
	logic [7:0]        lo_q;
	logic [7:0]        wdata_q;
	logic [7:0]        hi_q;
	logic [7:0]        rdata_q;
	logic [2:0]        cnt_q;
	logic [7:0]        p0_s1_q;
	logic [7:0]        p0_s2_q;
	logic              strobe_any;
	logic              drive_addr;
	logic              drive_data;

	// =====================================================
	// Read data synchroniser
	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
		begin
			p0_s1_q <= umc_pkg::DATA_RST;
			p0_s2_q <= umc_pkg::DATA_RST;
		end
		else
		begin
			p0_s1_q <= muxed_addr_data_port_i;
			p0_s2_q <= p0_s1_q;
		end
	end

	// =====================================================
	// Cycle sequencer
	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
		begin
			st_q  <= umc_pkg::BUS_IDLE;
			cnt_q <= 3'h0;
		end
		else
		begin
			case (st_q)
				umc_pkg::BUS_IDLE: if (mif.req) st_q <= umc_pkg::BUS_ADDR;
				umc_pkg::BUS_ADDR: st_q <= umc_pkg::BUS_HOLD;
				umc_pkg::BUS_HOLD:
				begin
					st_q  <= umc_pkg::BUS_STRB;
					cnt_q <= 3'(umc_pkg::STRB_CYC - 1);
				end
				umc_pkg::BUS_STRB:
				begin
					if (cnt_q == 3'h0)
						st_q <= umc_pkg::BUS_END;
					else
						cnt_q <= cnt_q - 3'h1;
				end
				umc_pkg::BUS_END: st_q <= umc_pkg::BUS_IDLE;
				default: st_q <= umc_pkg::BUS_IDLE;
			endcase
		end
	end

	// =====================================================
	// Request capture and address holding
	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
		begin
			kind_q  <= umc_pkg::ACC_CODE;
			lo_q    <= umc_pkg::DATA_RST;
			wdata_q <= umc_pkg::DATA_RST;
			hi_q    <= umc_pkg::HI_ADDR_RST;
		end
		else if (st_q == umc_pkg::BUS_IDLE && mif.req)
		begin
			kind_q  <= mif.kind;
			lo_q    <= mif.addr[7:0];
			wdata_q <= mif.wdata;
			hi_q    <= mif.addr[15:8]; // R7
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
			rdata_q <= umc_pkg::DATA_RST;
		else if (st_q == umc_pkg::BUS_STRB && cnt_q == 3'h0 && kind_q != umc_pkg::ACC_WRITE)
			rdata_q <= p0_s2_q;
	end

	// =====================================================
	// Pin drive
	assign addr_latch = (st_q == umc_pkg::BUS_ADDR); // R16
	assign drive_addr = (st_q == umc_pkg::BUS_ADDR) || (st_q == umc_pkg::BUS_HOLD);
	assign drive_data = (kind_q == umc_pkg::ACC_WRITE)
		&& ((st_q == umc_pkg::BUS_STRB) || (st_q == umc_pkg::BUS_END));
	// Open drain: only zeros are driven
	assign muxed_addr_data_port_o  = 8'h00;
	assign muxed_addr_data_port_oe = drive_addr ? ~lo_q : (drive_data ? ~wdata_q : 8'h00); // R6 R18
	assign high_address_port       = hi_q;
	assign program_fetch_strobe_n  =
		!(st_q == umc_pkg::BUS_STRB && kind_q == umc_pkg::ACC_CODE); // R8
	assign read_strobe_n  = !(st_q == umc_pkg::BUS_STRB && kind_q == umc_pkg::ACC_READ); // R9
	assign write_strobe_n = !(st_q == umc_pkg::BUS_STRB && kind_q == umc_pkg::ACC_WRITE); // R10
	assign strobe_any     = !(program_fetch_strobe_n && read_strobe_n && write_strobe_n);

	assign mif.busy  = (st_q != umc_pkg::BUS_IDLE);
	assign mif.done  = (st_q == umc_pkg::BUS_END);
	assign mif.rdata = rdata_q;

	// =====================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (core_rst);

	sequence s_addr_phase;
		addr_latch ##1 !addr_latch && !strobe_any;
	endsequence

	sequence s_strobe_phase;
		strobe_any[*4] ##1 !strobe_any;
	endsequence

	a_bus_cycle_order: assert property ($rose(addr_latch) |-> s_addr_phase ##1 s_strobe_phase) // R16
		else $error("bus cycle phases out of order");
	a_fetch_strobe_kind: assert property (!program_fetch_strobe_n |-> kind_q == umc_pkg::ACC_CODE
		&& read_strobe_n && write_strobe_n) // R8
		else $error("fetch strobe on non-fetch cycle");
	a_read_strobe_kind: assert property (!read_strobe_n |-> kind_q == umc_pkg::ACC_READ) // R9
		else $error("read strobe on non-read cycle");
	a_write_data_hold: assert property (!write_strobe_n |-> muxed_addr_data_port_oe == ~wdata_q
		##1 muxed_addr_data_port_oe == ~wdata_q) // R18
		else $error("write data not held under strobe");
	a_write_strobe_seen: assert property ($rose(addr_latch) && kind_q == umc_pkg::ACC_WRITE
		|-> ##2 !write_strobe_n) // R10
		else $error("write cycle without write strobe");
	a_low_addr_drive: assert property (addr_latch |-> muxed_addr_data_port_oe == ~lo_q) // R6
		else $error("low address not on muxed port");
	a_high_addr_hold: assert property (strobe_any |-> high_address_port == hi_q
		&& $stable(high_address_port)) // R7
		else $error("high address moved during cycle");

endmodule

// >>> bench/umc_far_model.sv
// Far side model: address latch, program and data memories, modem controller
`timescale 1ns/1ns
module umc_far_model
(
	// Clock
	input  wire logic       sys_clk,
	// External bus pins
	input  wire logic       addr_latch,
	input  wire logic [7:0] port_oe,
	input  wire logic [7:0] high_addr,
	input  wire logic       fetch_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	output logic [7:0]      port_pin,
	// Modem controller interrupt causes
	input  wire logic [3:0] irq_cause,
	output logic            irq_out
);
	logic [7:0]  low_q;
	logic [7:0]  drive;
	logic [15:0] full_addr;
	logic [7:0]  data_mem [logic [15:0]];

	// ====================================================
	// Address latch
	initial low_q = 8'h00;
	assign full_addr = {high_addr, low_q};
	always @(posedge sys_clk)
	begin
		if (addr_latch === 1'b1)
			low_q <= port_pin;
	end

	// ====================================================
	// Memories; released lines float to the pullup level
	always_comb
	begin
		drive = 8'hFF;
		if (fetch_n === 1'b0)
			drive = full_addr[7:0] ^ full_addr[15:8] ^ 8'h3C;
		else if (rd_n === 1'b0 && data_mem.exists(full_addr))
			drive = data_mem[full_addr];
	end
	assign port_pin = ~port_oe & drive;
	always @(posedge wr_n)
	begin
		data_mem[full_addr] = port_pin;
	end

	// ====================================================
	// Modem controller raises the irq on any event
	assign irq_out = |irq_cause;
endmodule

// >>> bench/usb_modem_controller_pins_tb.sv
// Self-checking bench for the modem bridge pin block
`timescale 1ns/1ns
module usb_modem_controller_pins_tb;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reset_pin = 1'b0;
	logic        code_source_strap = 1'b0;
	logic        full_speed_strap = 1'b1;
	logic        loop_select_strap = 1'b1;
	logic        ring_wake_input = 1'b1;
	logic        overcurrent_sense = 1'b1;
	logic [3:0]  irq_cause = 4'h0;
	logic        mem_req = 1'b0;
	logic [2:0]  mem_kind = 3'h1;
	logic [15:0] mem_addr = 16'h0000;
	logic [7:0]  mem_wdata = 8'h00;
	logic [4:0]  core_ctl = 5'h00;
	logic        frame_locked = 1'b0;
	logic        sof_seen = 1'b0;
	logic        enter_idle = 1'b0;
	logic        enter_powerdown = 1'b0;
	logic        host_irq_input;
	logic        addr_latch;
	logic [7:0]  port_pin;
	logic [7:0]  port_oe;
	logic [7:0]  port_o;
	logic [7:0]  high_address_port;
	logic        fetch_n;
	logic        rd_n;
	logic        wr_n;
	logic [4:0]  ind_n;
	logic        frame_start_n;
	logic        mem_ready;
	logic        mem_done;
	logic [7:0]  mem_rdata;
	logic        mem_on_chip;
	logic [2:0]  mode;
	logic        full_reset;
	logic        code_off_chip;
	logic        full_speed_mode;
	logic        overcurrent;
	logic        host_irq_line;
	logic        ring_notify;
	logic [2:0]  strb_seen = 3'h0;
	logic [9:0]  note;
	logic [9:0]  exp_q [$];
	logic [31:0] rng_q = 32'h2a97_bae1;
	logic [31:0] r;
	logic [15:0] a [6];
	logic [7:0]  d [6];
	int          failures = 0;
	int          total_checks = 0;
	int          ring_cnt = 0;
	int          low_cnt = 0;

	// ====================================================
	// Clock, design and far side
	always #20 sys_clk = ~sys_clk;

	umc_pins_top i_dut
	(
		.sys_clk(sys_clk), .rst_n(rst_n), .reset_pin(reset_pin),
		.code_source_strap(code_source_strap), .full_speed_strap(full_speed_strap),
		.loop_select_strap(loop_select_strap), .host_irq_input(host_irq_input),
		.ring_wake_input(ring_wake_input), .overcurrent_sense(overcurrent_sense),
		.addr_latch(addr_latch), .muxed_addr_data_port_i(port_pin),
		.muxed_addr_data_port_o(port_o), .muxed_addr_data_port_oe(port_oe),
		.high_address_port(high_address_port), .program_fetch_strobe_n(fetch_n),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .led_ready_n(ind_n[4]),
		.led_carrier_detect_n(ind_n[3]), .led_data_n(ind_n[2]),
		.isolated_power_switch_n(ind_n[1]), .modem_side_reset_out_n(ind_n[0]),
		.frame_start_n(frame_start_n), .mem_req(mem_req), .mem_kind(mem_kind),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
		.mem_done(mem_done), .mem_rdata(mem_rdata), .mem_on_chip(mem_on_chip),
		.core_ready_led(core_ctl[4]), .core_carrier_led(core_ctl[3]),
		.core_data_led(core_ctl[2]), .core_power_on(core_ctl[1]),
		.core_modem_reset(core_ctl[0]), .frame_locked(frame_locked), .sof_seen(sof_seen),
		.enter_idle(enter_idle), .enter_powerdown(enter_powerdown), .mode(mode),
		.full_reset(full_reset), .code_off_chip(code_off_chip),
		.full_speed_mode(full_speed_mode), .overcurrent(overcurrent),
		.host_irq_line(host_irq_line), .ring_notify(ring_notify)
	);

	umc_far_model i_far
	(
		.sys_clk(sys_clk), .addr_latch(addr_latch), .port_oe(port_oe),
		.high_addr(high_address_port), .fetch_n(fetch_n), .rd_n(rd_n), .wr_n(wr_n),
		.port_pin(port_pin), .irq_cause(irq_cause), .irq_out(host_irq_input)
	);

	// ====================================================
	// Helpers
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		rng_q = rng_q ^ (rng_q << 13);
		rng_q = rng_q ^ (rng_q >> 17);
		rng_q = rng_q ^ (rng_q << 5);
		return rng_q;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// One request; note: [9] on chip, [8] compare data, [7:0] data
	task automatic mem_op(input logic [2:0] kind, input logic [15:0] addr,
		input logic [7:0] wd, input logic [9:0] nt, input logic [2:0] strb);
		int n;
		n = 0;
		while (mem_ready !== 1'b1 && n < 50)
		begin
			cyc(1);
			n++;
		end
		mem_req = 1'b1;
		mem_kind = kind;
		mem_addr = addr;
		mem_wdata = wd;
		exp_q.push_back(nt);
		strb_seen = 3'h0;
		cyc(1);
		mem_req = 1'b0;
		if (!nt[9])
		begin
			check("addr_latch", 16'h0001, {15'h0000, addr_latch});
			check("port_oe", {8'h00, ~addr[7:0]}, {8'h00, port_oe});
			check("port_o", 16'h0000, {8'h00, port_o});
		end
		n = 0;
		while (exp_q.size() != 0 && n < 20)
		begin
			cyc(1);
			n++;
		end
		check("pending", 16'h0000, 16'(exp_q.size()));
		check("strobes", {13'h0000, strb}, {13'h0000, strb_seen});
		if (!nt[9])
			check("high_address_port", {8'h00, addr[15:8]}, {8'h00, high_address_port});
	endtask

	// ====================================================
	// Output watcher
	always @(posedge sys_clk)
	begin
		strb_seen = strb_seen | {~wr_n, ~rd_n, ~fetch_n};
		ring_cnt = ring_cnt + (ring_notify === 1'b1);
		low_cnt = low_cnt + (frame_start_n === 1'b0);
		if (mem_done === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("unexpected mem_done", 16'h0000, 16'h0001);
			else
			begin
				note = exp_q.pop_front();
				check("mem_on_chip", {15'h0000, note[9]}, {15'h0000, mem_on_chip});
				if (note[8])
					check("mem_rdata", {8'h00, note[7:0]}, {8'h00, mem_rdata});
			end
		end
	end

	// ====================================================
	// Main sequence
	initial
	begin
		cyc(10);
		rst_n = 1'b1;
		cyc(2);
		check("code_off_chip", 16'h0001, {15'h0000, code_off_chip});
		for (int i = 0; i < 6; i++)
		begin
			r = rnd();
			a[i] = {r[15:3], 3'(i)};
			d[i] = r[23:16];
			mem_op(umc_pkg::ACC_WRITE, a[i], d[i], 10'h000, 3'h4);
		end
		for (int i = 0; i < 6; i++)
			mem_op(umc_pkg::ACC_READ, a[i], 8'h00, {2'h1, d[i]}, 3'h2);
		mem_op(umc_pkg::ACC_CODE, 16'h0040, 8'h00, 10'h17C, 3'h1);
		for (int i = 0; i < 8; i++)
		begin
			r = rnd();
			core_ctl = r[4:0];
			overcurrent_sense = r[5];
			irq_cause = r[9:6];
			{full_speed_strap, loop_select_strap} = r[11:10];
			cyc(2);
			check("indicators", {11'h000, ~r[4:0]}, {11'h000, ind_n});
			cyc(3);
			check("overcurrent", {15'h0000, ~r[5]}, {15'h0000, overcurrent});
			check("host_irq_line", {15'h0000, |r[9:6]}, {15'h0000, host_irq_line});
			check("full_speed_mode", {15'h0000, &r[11:10]}, {15'h0000, full_speed_mode});
		end
		ring_wake_input = 1'b0;
		ring_cnt = 0;
		cyc(10);
		ring_wake_input = 1'b1;
		cyc(10);
		check("ring_notify pulses", 16'h0001, 16'(ring_cnt));
		for (int j = 0; j < 2; j++)
		begin
			frame_locked = (j == 0);
			sof_seen = 1'b1;
			cyc(1);
			sof_seen = 1'b0;
			low_cnt = 0;
			cyc(3);
			sof_seen = 1'b1;
			cyc(1);
			sof_seen = 1'b0;
			cyc(12);
			check("frame_start_n low cycles", (j == 0) ? 16'h0008 : 16'h0000, 16'(low_cnt));
		end
		for (int j = 0; j < 2; j++)
		begin
			{enter_powerdown, enter_idle} = (j == 0) ? 2'h1 : 2'h2;
			cyc(1);
			{enter_powerdown, enter_idle} = 2'h0;
			cyc(1);
			check("mode", {13'h0000, (j == 0) ? umc_pkg::MODE_IDLE : umc_pkg::MODE_PDOWN},
				{13'h0000, mode});
			check("mem_ready", 16'h0000, {15'h0000, mem_ready});
			reset_pin = 1'b1;
			cyc(5);
			reset_pin = 1'b0;
			cyc(4);
			check("mode", {13'h0000, umc_pkg::MODE_NORMAL}, {13'h0000, mode});
		end
		reset_pin = 1'b1;
		code_source_strap = 1'b1;
		cyc(60);
		check("full_reset early", 16'h0000, {15'h0000, full_reset});
		cyc(10);
		check("full_reset", 16'h0001, {15'h0000, full_reset});
		check("indicators in reset", 16'h001F, {11'h000, ind_n});
		reset_pin = 1'b0;
		cyc(4);
		check("full_reset released", 16'h0000, {15'h0000, full_reset});
		check("code_off_chip", 16'h0000, {15'h0000, code_off_chip});
		mem_op(umc_pkg::ACC_CODE, 16'h0100, 8'h00, 10'h200, 3'h0);
		mem_op(umc_pkg::ACC_CODE, 16'h2000, 8'h00, 10'h11C, 3'h1);
		conclude();
	end

	// ====================================================
	// Watchdog
	initial
	begin
		#800000;
		failures++;
		conclude();
	end
endmodule
